// File: rtl/adcof_defines.vh
// Constants for the converter output formatter: offsets, fields, counts
`ifndef ADCOF_DEFINES_VH
`define ADCOF_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define ADCOF_OFS_CONTROL     8'h00
`define ADCOF_OFS_STATUS      8'h04
`define ADCOF_OFS_LASTWORD    8'h08

// ****************************************
// Control register fields and reset value
// ****************************************
`define ADCOF_CTL_MODE_LSB    0
`define ADCOF_CTL_MODE_MSB    1
`define ADCOF_CTL_FMT_LSB     2
`define ADCOF_CTL_FMT_MSB     3
`define ADCOF_CTL_DCOINV_BIT  4
`define ADCOF_CTL_WIDTH       5
`define ADCOF_CTL_RESET       5'h00

// ****************************************
// Power modes
// ****************************************
`define ADCOF_MODE_NORMAL     2'h0
`define ADCOF_MODE_POWERDOWN  2'h1
`define ADCOF_MODE_STANDBY    2'h2

// ****************************************
// Output codings
// ****************************************
`define ADCOF_FMT_OFFSET      2'h0
`define ADCOF_FMT_TWOS        2'h1
`define ADCOF_FMT_GRAY        2'h2

// ****************************************
// Status register bits
// ****************************************
`define ADCOF_STS_PINMODE     0
`define ADCOF_STS_ASLEEP      1
`define ADCOF_STS_RANGE       2
`define ADCOF_STS_PINFMT      3
`define ADCOF_STS_REFON       4

// ****************************************
// Data path
// ****************************************
`define ADCOF_WORD_WIDTH      12
`define ADCOF_LATENCY         12
`define ADCOF_CODE_TOP        12'hFFF
`define ADCOF_CODE_BOTTOM     12'h000
`define ADCOF_SIGN_FLIP       12'h800
`define ADCOF_GRAY_TOP        12'h800

`endif

// File: rtl/adcof_output_formatter.v
// Output stage of a 12-bit sampling converter: coding, range flag, drivers
//
// Function
// - Power-down pin high shuts reference, biasing and internal clocking.
// - While powered down all output drivers go high impedance.
// - Power-down pin low again resumes normal conversion.
// - Standby mode keeps the reference powered for faster wake-up.
// - Data drivers enabled while output enable low, high impedance while high.
// - In pin-strapped setup the format pin picks offset binary or twos.
// - Format pin honoured only if chip select high at start, until chip select goes low.
// - Register setup also offers Gray code as a third coding.
// - Positive full scale clamps to FFF, 7FF and 800 by coding.
// - Negative full scale clamps to 000, 800 and C00 by coding.
// - Zero input gives 800 offset binary, zero in twos and Gray.
// - Range flag low inside the span, high beyond either end.
// - Range flag stays high until an in-range conversion completes.
// - Range flag and its data word share the same pipeline latency.
// - Each result appears exactly 12 sample clocks after its sampling edge.
// - Latched outputs change after each rising sample clock edge.
// - Data clock output rises with valid data; polarity bit inverts it.
// - Each result is a parallel 12-bit word.
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "adcof_defines.vh"

module adcof_output_formatter #(
	parameter WIDTH   = `ADCOF_WORD_WIDTH,
	parameter LATENCY = `ADCOF_LATENCY
)(
	input  wire             clock,           // System clock, 200 MHz
	input  wire             reset_n,         // Synchronous reset, active low
	input  wire             psel,            // APB select
	input  wire             penable,         // APB access phase
	input  wire             pwrite,          // APB write
	input  wire [7:0]       paddr,           // APB byte address
	input  wire [31:0]      pwdata,          // APB write data
	output reg  [31:0]      prdata,          // APB read data
	output reg              pready,          // APB ready
	output reg              pslverr,         // APB error, unmapped address
	input  wire             sampleClock,     // Sample clock pin
	input  wire [WIDTH-1:0] coreCode,        // Core result, offset binary
	input  wire             coreOver,        // Core: input above span
	input  wire             coreUnder,       // Core: input below span
	input  wire             power_down_pin,  // Power-down pin, high asleep
	input  wire             output_enable_n, // Output enable pin
	input  wire             format_select_pin, // Strapped format pin
	input  wire             chip_select_n,   // Serial chip select pin
	output reg  [WIDTH-1:0] dataOut,         // Output data word
	output reg              dataOutEn,       // Drive enable, data word
	output reg              outOfRange,      // Range flag
	output reg              outOfRangeEn,    // Drive enable, range flag
	output reg              data_clock_out,  // Data clock output
	output reg              dataClockEn,     // Drive enable, data clock
	output reg              referencePowered, // Reference and buffer on
	output reg              biasPowered,     // Bias networks on
	output reg              coreClockOn      // Internal clocking on
);

	// ****************************************
	// Coding functions
	// ****************************************
	// Clamped offset-binary code into the requested coding
	function [WIDTH-1:0] encode;
		input [WIDTH-1:0] code;
		input [1:0]       fmt;
		reg   [WIDTH-1:0] twos;
		begin
			twos = code ^ `ADCOF_SIGN_FLIP;
			case (fmt)
				`ADCOF_FMT_TWOS:
					encode = twos;
				`ADCOF_FMT_GRAY:
					// Top code breaks the plain reflected pattern
					if (code == `ADCOF_CODE_TOP)
						encode = `ADCOF_GRAY_TOP;
					else
						encode = twos ^ (twos >> 1);
				default:
					encode = code;
			endcase
		end
	endfunction

	// Strapped pin level into a coding; low is the default offset binary
	function [1:0] strap_coding;
		input level;
		begin
			if (level)
				strap_coding = `ADCOF_FMT_TWOS;
			else
				strap_coding = `ADCOF_FMT_OFFSET;
		end
	endfunction

	// Word and flag drivers share one enable condition
	function drivers_on;
		input sleeping;
		input oeHigh;
		begin
			drivers_on = ~sleeping & ~oeHigh;
		end
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	reg [1:0]       clkSync;
	reg [1:0]       pdSync;
	reg [1:0]       oeSync;
	reg [1:0]       fmtSync;
	reg [1:0]       csSync;
	reg [1:0]       overSync;
	reg [1:0]       underSync;
	reg [WIDTH-1:0] codeMeta;
	reg [WIDTH-1:0] codeSync;
	reg             clkLast;

	always @(posedge clock)
	begin
		if (!reset_n)
		begin
			clkSync   <= 2'h0;
			pdSync    <= 2'h0;
			oeSync    <= 2'h3;
			fmtSync   <= 2'h0;
			overSync  <= 2'h0;
			underSync <= 2'h0;
			codeMeta  <= {WIDTH{1'b0}};
			codeSync  <= {WIDTH{1'b0}};
			clkLast   <= 1'b0;
		end
		else
		begin
			clkSync   <= {clkSync[0], sampleClock};
			pdSync    <= {pdSync[0], power_down_pin};
			oeSync    <= {oeSync[0], output_enable_n};
			fmtSync   <= {fmtSync[0], format_select_pin};
			overSync  <= {overSync[0], coreOver};
			underSync <= {underSync[0], coreUnder};
			codeMeta  <= coreCode;
			codeSync  <= codeMeta;
			clkLast   <= clkSync[1];
		end
	end

	// Chip select syncs through reset too, so the strap taken at the
	// first edge after release is the real pin level, not a reset value
	always @(posedge clock)
	begin
		csSync <= {csSync[0], chip_select_n};
	end

	// Rising sample clock edge; the core result is steady around it
	wire sampleEdge = clkSync[1] & ~clkLast;

	// ****************************************
	// Configuration registers
	// ****************************************
	reg [`ADCOF_CTL_WIDTH-1:0] control;
	reg                        pinMode;
	reg                        strapTaken;

	wire [1:0] regMode  = control[`ADCOF_CTL_MODE_MSB:`ADCOF_CTL_MODE_LSB];
	wire [1:0] regFmt   = control[`ADCOF_CTL_FMT_MSB:`ADCOF_CTL_FMT_LSB];
	wire       dcoInv   = control[`ADCOF_CTL_DCOINV_BIT];

	// Pin-strapped setup wins over the register format only until the
	// serial port is used once; only a reset brings it back
	wire [1:0] activeFmt = pinMode ?
		strap_coding(fmtSync[1]) :
		regFmt;

	always @(posedge clock)
	begin
		if (!reset_n)
		begin
			pinMode    <= 1'b0;
			strapTaken <= 1'b0;
		end
		else if (!strapTaken)
		begin
			pinMode    <= csSync[1];
			strapTaken <= 1'b1;
		end
		else if (!csSync[1])
			pinMode <= 1'b0;
	end

	// ****************************************
	// Power state
	// ****************************************
	wire asleep  = pdSync[1] | (regMode != `ADCOF_MODE_NORMAL);
	wire refDown = pdSync[1] | (regMode == `ADCOF_MODE_POWERDOWN);

	always @(posedge clock)
	begin
		if (!reset_n)
		begin
			referencePowered <= 1'b0;
			biasPowered      <= 1'b0;
			coreClockOn      <= 1'b0;
		end
		else
		begin
			referencePowered <= ~refDown;
			biasPowered      <= ~asleep;
			coreClockOn      <= ~asleep;
		end
	end

	// ****************************************
	// Conversion pipeline
	// ****************************************
	// Stores clamped code and flag; coding is applied at the output
	// stage so a format change reaches the pins on the next word
	reg [WIDTH-1:0] pipeCode [0:LATENCY-1];
	reg             pipeFlag [0:LATENCY-1];
	integer         i;

	wire             inFlag  = overSync[1] | underSync[1];
	wire [WIDTH-1:0] inCode  = overSync[1] ? `ADCOF_CODE_TOP :
		(underSync[1] ? `ADCOF_CODE_BOTTOM : codeSync);
	wire             advance = sampleEdge & ~asleep;

	always @(posedge clock)
	begin
		if (!reset_n)
		begin
			for (i = 0; i < LATENCY; i = i + 1)
			begin
				pipeCode[i] <= `ADCOF_SIGN_FLIP;
				pipeFlag[i] <= 1'b0;
			end
		end
		else if (advance)
		begin
			pipeCode[0] <= inCode;
			pipeFlag[0] <= inFlag;
			for (i = 1; i < LATENCY; i = i + 1)
			begin
				pipeCode[i] <= pipeCode[i-1];
				pipeFlag[i] <= pipeFlag[i-1];
			end
		end
	end

	// ****************************************
	// Output latches and drivers
	// ****************************************
	always @(posedge clock)
	begin
		if (!reset_n)
		begin
			dataOut      <= `ADCOF_SIGN_FLIP;
			outOfRange   <= 1'b0;
			dataOutEn    <= 1'b0;
			outOfRangeEn <= 1'b0;
		end
		else
		begin
			if (advance)
			begin
				// Twelfth load after the sampling edge
				dataOut    <= encode(pipeCode[LATENCY-1],
					activeFmt);
				// Clears only with a later in-range word
				outOfRange <= pipeFlag[LATENCY-1];
			end
			dataOutEn    <= drivers_on(asleep, oeSync[1]);
			outOfRangeEn <= drivers_on(asleep, oeSync[1]);
		end
	end

	// ****************************************
	// Data clock output
	// ****************************************
	// Output enable leaves the data clock running, so a receiver that
	// shares the word lines still sees a steady capture clock
	always @(posedge clock)
	begin
		if (!reset_n)
		begin
			data_clock_out <= 1'b0;
			dataClockEn    <= 1'b0;
		end
		else
		begin
			dataClockEn    <= ~asleep;
			// Rises mid-cycle, while the word is steady; the polarity
			// bit moves the rising edge onto the word change instead
			data_clock_out <= ~asleep & (clkSync[1] ~^ dcoInv);
		end
	end

	// ****************************************
	// APB slave
	// ****************************************
	wire setupPhase = psel & ~penable;
	wire writeTaken = psel & penable & pready & pwrite & ~pslverr;
	wire mapped     = (paddr == `ADCOF_OFS_CONTROL) |
		(paddr == `ADCOF_OFS_STATUS) | (paddr == `ADCOF_OFS_LASTWORD);

	reg [31:0] readValue;

	always @*
	begin
		readValue = 32'h00000000;
		case (paddr)
			`ADCOF_OFS_CONTROL:
				readValue[`ADCOF_CTL_WIDTH-1:0] = control;
			`ADCOF_OFS_STATUS:
			begin
				readValue[`ADCOF_STS_PINMODE] = pinMode;
				readValue[`ADCOF_STS_ASLEEP]  = asleep;
				readValue[`ADCOF_STS_RANGE]   = outOfRange;
				readValue[`ADCOF_STS_PINFMT]  = fmtSync[1];
				readValue[`ADCOF_STS_REFON]   = referencePowered;
			end
			`ADCOF_OFS_LASTWORD:
				readValue[WIDTH-1:0] = dataOut;
			default:
				readValue = 32'h00000000;
		endcase
	end

	always @(posedge clock)
	begin
		if (!reset_n)
		begin
			control <= `ADCOF_CTL_RESET;
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			// One wait-free access phase follows every setup cycle
			pready  <= setupPhase;
			pslverr <= setupPhase & ~mapped;
			prdata  <= (setupPhase & ~pwrite) ? readValue : 32'h00000000;
			if (writeTaken && paddr == `ADCOF_OFS_CONTROL)
				control <= pwdata[`ADCOF_CTL_WIDTH-1:0];
		end
	end

endmodule // adcof_output_formatter

// File: testbench/adcof_output_formatter_chk.sv
// Port checker for the converter output formatter
`timescale 1ns/1ps
module adcof_output_formatter_chk #(
	parameter WIDTH = 12,
	parameter LATENCY = 12
)(
	input logic		clock,		// System clock
	input logic		reset_n,	// Reset, active low
	input logic		psel,		// APB select
	input logic		penable,	// APB access
	input logic		pready,		// APB ready
	input logic		pslverr,	// APB error
	input logic		sampleClock,	// Sample clock pin
	input logic		power_down_pin,	// Power-down pin
	input logic		output_enable_n, // Output enable pin
	input logic [WIDTH-1:0]	dataOut,	// Output word
	input logic		dataOutEn,	// Word enable
	input logic		outOfRange,	// Range flag
	input logic		outOfRangeEn,	// Flag enable
	input logic		data_clock_out,	// Data clock
	input logic		dataClockEn,	// Data clock enable
	input logic		referencePowered, // Reference on
	input logic		biasPowered,	// Bias on
	input logic		coreClockOn	// Clocking on
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	AST_PD_POWER:
		assert property (power_down_pin[*4] |->
			!(referencePowered || biasPowered || coreClockOn))
		else $error("power still on while powered down");
	AST_PD_HIZ:
		assert property (power_down_pin[*4] |->
			!(dataOutEn || outOfRangeEn || dataClockEn))
		else $error("driver enabled while powered down");
	AST_OE_HIZ:
		assert property ($rose(output_enable_n) |-> ##[1:4] !dataOutEn)
		else $error("data drivers stay on with output enable high");
	AST_STANDBY_REF:
		assert property (biasPowered |-> referencePowered)
		else $error("bias on with reference off");
	AST_FLAG_CLAMP:
		assert property (outOfRange |-> dataOut inside
			{12'hFFF, 12'h7FF, 12'h800, 12'h000, 12'hC00})
		else $error("range flag high with unclamped word");
	AST_FLAG_HOLD:
		assert property ((!sampleClock && coreClockOn)[*8] |->
			$stable(outOfRange))
		else $error("range flag moved without a sample edge");
	AST_DCO_QUIET:
		assert property ((!dataClockEn)[*2] |-> !data_clock_out)
		else $error("data clock toggles while released");
	AST_APB_READY:
		assert property (psel && !penable |=> pready)
		else $error("no ready in access phase");
	AST_APB_PULSE:
		assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	AST_APB_ERR:
		assert property (pslverr |-> pready)
		else $error("error without ready");
	cover property ($rose(outOfRange));
	cover property (pslverr);
	cover property (referencePowered && !biasPowered);
endmodule // adcof_output_formatter_chk

bind adcof_output_formatter adcof_output_formatter_chk #(
	.WIDTH(WIDTH),
	.LATENCY(LATENCY)
) adcof_output_formatter_chk_i (.*);

// File: testbench/adcof_capture_model.sv
// Receiving register that latches words on the data clock
`timescale 1ns/1ps
module adcof_capture_model (
	input logic		dataClk,	// Data clock line
	input logic [11:0]	busWord,	// Resolved data lines
	input logic		busFlag,	// Resolved range flag line
	output logic [11:0]	capWord,	// Last captured word
	output logic [1:0]	capClass	// 0 in range, 1 under, 3 over
);
	initial
	begin
		capWord = 12'h000;
		capClass = 2'h0;
	end
	always @(posedge dataClk)
	begin
		capWord <= busWord;
		capClass <= {busFlag & busWord[11], busFlag};
	end
endmodule // adcof_capture_model

// File: testbench/adcof_tb.sv
// Self-checking bench for the converter output formatter
`timescale 1ns/1ps
module tb;
	logic		clock = 1'b0;
	logic		reset_n = 1'b0;
	logic		psel = 1'b0;
	logic		penable = 1'b0;
	logic		pwrite = 1'b0;
	logic [7:0]	paddr = 8'h00;
	logic [31:0]	pwdata = 32'h0;
	logic		sampleClock = 1'b0;
	logic [11:0]	coreCode = 12'h000;
	logic		coreOver = 1'b0;
	logic		coreUnder = 1'b0;
	logic		power_down_pin = 1'b0;
	logic		output_enable_n = 1'b0;
	logic		format_select_pin = 1'b0;
	logic		chip_select_n = 1'b1;
	logic [31:0]	prdata, rd;
	logic [11:0]	dataOut, busWord, capWord;
	logic		pready, pslverr, dataOutEn, outOfRange, outOfRangeEn;
	logic		data_clock_out, dataClockEn, referencePowered, er;
	logic		biasPowered, coreClockOn, busFlag, dcoLine;
	logic [1:0]	capClass;
	logic [1:0]	fmt = 2'h0;
	logic		inv = 1'b0;
	logic [13:0]	pend [$];
	int		err_total = 0;
	int		checks_done = 0;
	int		seed = 47127;

	always #2.5 clock = ~clock;
	// Released lines show the inverse; the clock line has a pull-down
	assign busWord = dataOutEn ? dataOut : ~dataOut;
	assign busFlag = outOfRangeEn ? outOfRange : ~outOfRange;
	assign dcoLine = dataClockEn & data_clock_out;

	adcof_output_formatter adcof_output_formatter_i (.*);
	adcof_capture_model adcof_capture_model_i (
		.dataClk(dcoLine),
		.busWord(busWord),
		.busFlag(busFlag),
		.capWord(capWord),
		.capClass(capClass)
	);

	function automatic logic [11:0] enc(logic [13:0] s, logic [1:0] f);
		logic [11:0] c;
		c = s[13] ? 12'hFFF : s[12] ? 12'h000 : s[11:0];
		if (f == 2'h1 || f == 2'h2) c = c ^ 12'h800;
		if (f == 2'h2) c = (c == 12'h7FF) ? 12'h800 : c ^ (c >> 1);
		return c;
	endfunction

	task chk(string n, logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("unexpected %s expected %h seen %h", n, e, g);
			err_total++;
		end
	endtask

	task apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// No count of wait states: the watchdog ends a hung access
		do
		begin
			@(posedge clock);
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One sample period: 16 clocks low, 16 high
	task smp(logic [13:0] s);
		logic [13:0] o;
		@(posedge clock);
		{coreOver, coreUnder, coreCode} <= s;
		repeat (9) @(posedge clock);
		sampleClock <= 1'b1;
		pend.push_back(s);
		repeat (16) @(posedge clock);
		sampleClock <= 1'b0;
		repeat (6) @(posedge clock);
		if (pend.size() > 12)
		begin
			o = pend.pop_front();
			chk("dataOut", enc(o, fmt), dataOut);
			chk("outOfRange", o[13] | o[12], outOfRange);
			chk("dataOutEn", 1'b1, dataOutEn);
			chk("dcoPhase", !inv, data_clock_out);
			if (!inv) chk("capWord", enc(o, fmt), capWord);
			if (fmt == 2'h0 && !inv)
				chk("capClass", {o[13], |o[13:12]}, capClass);
		end
	endtask

	task run(int k);
		int r;
		repeat (k)
		begin
			r = $random(seed);
			if (r[17:15] == 3'h0) r[11:0] = 12'h800;
			if (r[17:15] == 3'h1) r[11:0] = 12'hFFF;
			if (r[17:15] == 3'h2) r[11:0] = 12'h000;
			smp({r[14:13] == 2'h0, r[14:13] == 2'h1, r[11:0]});
		end
	endtask

	task finish_test;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		repeat (4) @(posedge clock);
		chk("dataOut", 12'h800, dataOut);
		reset_n <= 1'b1;
		apb(1'b0, 8'h00, 32'h0);
		chk("control", 32'h0, rd);
		apb(1'b0, 8'h04, 32'h0);
		chk("pinMode", 1'b1, rd[0]);
		apb(1'b0, 8'h0C, 32'h0);
		chk("pslverr", 1'b1, er);
		chk("prdata", 32'h0, rd);
		apb(1'b1, 8'h00, 32'h8);
		run(20);
		format_select_pin <= 1'b1;
		fmt = 2'h1;
		run(16);
		chip_select_n <= 1'b0;
		for (int f = 0; f < 4; f++)
		begin
			apb(1'b1, 8'h00, f << 2);
			fmt = (f == 3) ? 2'h0 : f[1:0];
			run(14);
		end
		apb(1'b1, 8'h00, 32'h10);
		inv = 1'b1;
		fmt = 2'h0;
		run(14);
		apb(1'b1, 8'h00, 32'h0);
		inv = 1'b0;
		output_enable_n <= 1'b1;
		repeat (5) @(posedge clock);
		chk("oeOff", 3'h1, {dataOutEn, outOfRangeEn, dataClockEn});
		output_enable_n <= 1'b0;
		power_down_pin <= 1'b1;
		repeat (5) @(posedge clock);
		chk("pdPower", 3'h0, {referencePowered, biasPowered, coreClockOn});
		chk("pdDrive", 3'h0, {dataOutEn, outOfRangeEn, dataClockEn});
		power_down_pin <= 1'b0;
		repeat (5) @(posedge clock);
		chk("wake", 3'h7, {referencePowered, biasPowered, coreClockOn});
		run(14);
		apb(1'b1, 8'h00, 32'h2);
		repeat (4) @(posedge clock);
		chk("standby", 2'h2, {referencePowered, dataOutEn});
		apb(1'b1, 8'h00, 32'h0);
		run(14);
		finish_test;
	end

	initial
	begin
		#200000;
		err_total++;
		finish_test;
	end
endmodule // tb
